// ===== rtl/ecs_pkg.sv
// How it works
// - Memory is bytes; a word is even-aligned, high byte at the even address.
// - Address space is at most 16,384 bytes over an 8-bit data path.
// - Reset vector: workspace pointer at word 0, program counter at word 1.
// - External level vectors lie from byte 0004 to 0013, two words each.
// - Extended-operation trap vectors lie from 0040 to 007F, word pairs.
// - Load vector occupies the last four bytes, 3FFC to 3FFF.
// - Program counter holds the next instruction address and advances after fetch.
// - General registers are sixteen words at workspace pointer plus register offset.
// - A context switch fetches two vector words in four reads and saves three words in six stores; return takes six fetches; reset here makes no stores.
// - Context switches occur for call, return, extended operation, interrupts, reset, load.
// - Five levels: level 0 is reset, levels 1 to 4 are external and shareable.
// - Accept a level at or below the status mask, after the current instruction.
// - Load new pointer and counter, then save old context in registers 13-15.
// - After entry the mask becomes one less than the serviced level.
// - No further interrupt until the first service instruction has finished.
// - Higher level nests a switch; return resumes the lower routine.
// - Codes 011, 100, 101, 110 are levels 1 to 4 with vectors 0004, 0008, 000C, 0010.
// - Codes 000/001 are reset, 010 load, 111 none; reset and load ignore mask.
// - Reset removal traps via 0000/0002, clears status, and starts execution.
// - Load traps after the instruction via 3FFC, saves context, mask becomes 0.
package ecs_pkg;
  localparam int ADDR_W = 14;
  localparam logic [13:0] RESET_VEC = 14'h0000;
  localparam logic [13:0] LOAD_VEC = 14'h3FFC;
  localparam logic [13:0] EXTOP_BASE = 14'h0040;
  localparam logic [13:0] SAVE_OFFSET = 14'h001A;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [15:0] STATUS_CLEAR = 16'h0000;
  localparam logic [2:0] VEC_LAST = 3'h3;
  localparam logic [2:0] CTX_LAST = 3'h5;
  localparam logic [2:0] IC_RESET_A = 3'h0;
  localparam logic [2:0] IC_RESET_B = 3'h1;
  localparam logic [2:0] IC_LOAD = 3'h2;
  localparam logic [2:0] IC_NONE = 3'h7;
  localparam logic [2:0] LEVEL_BIAS = 3'h2;
  localparam logic [3:0] LOAD_MASK = 4'h0;
  localparam int MASK_LSB = 0;
  localparam int MASK_W = 4;
  localparam logic [1:0] SW_CALL = 2'h0;
  localparam logic [1:0] SW_EXTOP = 2'h1;
  localparam logic [1:0] SW_RETURN = 2'h2;
  typedef enum logic [2:0] {ST_RUN, ST_RSTHOLD, ST_FETCH, ST_STORE, ST_RESTORE} ecs_state_e;
  typedef enum logic [1:0] {CK_RESET, CK_LOAD, CK_LEVEL, CK_NONE} ecs_code_e;
endpackage

// ===== rtl/ecs_top.sv
`timescale 1ns/1ns
module ecs_top import ecs_pkg::*; (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [2:0] interruptCodeLines,
  input wire logic instrDone,
  input wire logic pcAdvance,
  input wire logic pcLoad,
  input wire logic [15:0] pcWData,
  input wire logic stLoad,
  input wire logic [15:0] stWData,
  input wire logic swReq,
  input wire logic [1:0] swKind,
  input wire logic [13:0] swVector,
  input wire logic [3:0] extOpNum,
  input wire logic [3:0] regSel,
  input wire logic memAck,
  input wire logic [7:0] memRData,
  output logic memReq,
  output logic memWe,
  output logic [13:0] memAddr,
  output logic [7:0] memWData,
  output logic [15:0] workspacePtr,
  output logic [15:0] programCounter,
  output logic [15:0] statusWord,
  output logic [13:0] regAddr,
  output logic busy,
  output logic writeInhibit,
  output logic switchDone
);
  logic rstMeta_q, rstSync_q;
  logic [2:0] icMeta_q, icSync_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else if (clkEn) begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  // Code lines change asynchronously, so only the second stage is decoded
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      icMeta_q <= IC_NONE;
      icSync_q <= IC_NONE;
    end else if (clkEn) begin
      icMeta_q <= interruptCodeLines;
      icSync_q <= icMeta_q;
    end
  end
  function automatic ecs_code_e codeKind(input logic [2:0] c);
    case (c)
      IC_RESET_A, IC_RESET_B: codeKind = CK_RESET;
      IC_LOAD: codeKind = CK_LOAD;
      IC_NONE: codeKind = CK_NONE;
      default: codeKind = CK_LEVEL;
    endcase
  endfunction
  // Level 0 is never produced here; it is the reset trap
  function automatic logic [2:0] codeLevel(input logic [2:0] c);
    codeLevel = c - LEVEL_BIAS;
  endfunction
  function automatic logic [13:0] lvlVector(input logic [2:0] l);
    lvlVector = {9'h000, l, 2'b00};
  endfunction
  function automatic logic [15:0] putByte(input logic [15:0] w, input logic lo, input logic [7:0] b);
    putByte = lo ? {w[15:8], b} : {b, w[7:0]};
  endfunction
  function automatic logic [7:0] ctxByte(input logic [2:0] c, input logic [15:0] wp, input logic [15:0] pc,
                                         input logic [15:0] st);
    logic [15:0] w;
    case (c[2:1])
      2'h0: w = wp;
      2'h1: w = pc;
      default: w = st;
    endcase
    ctxByte = c[0] ? w[7:0] : w[15:8];
  endfunction
  ecs_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [15:0] wp_q, wp_d, pc_q, pc_d, st_q, st_d;
  logic [15:0] nWp_q, nWp_d, nPc_q, nPc_d, nSt_q, nSt_d;
  logic [13:0] vec_q, vec_d;
  logic [3:0] newMask_q, newMask_d;
  logic doStore_q, doStore_d, isIrq_q, isIrq_d, setMask_q, setMask_d;
  logic block_q, block_d, done_q, done_d;
  logic memReq_q, memReq_d, memWe_q, memWe_d;
  logic [13:0] memAddr_q, memAddr_d, regAddr_q, regAddr_d;
  logic [7:0] memWData_q, memWData_d;
  ecs_code_e kind;
  logic [2:0] lvl;
  logic atBoundary, takeLoad, takeLvl;
  assign kind = codeKind(icSync_q);
  assign lvl = codeLevel(icSync_q);
  // Checked only at instruction boundaries, never mid-instruction
  assign atBoundary = state_q == ST_RUN && instrDone && !block_q && !swReq;
  assign takeLoad = atBoundary && kind == CK_LOAD;
  assign takeLvl = atBoundary && kind == CK_LEVEL && {1'b0, lvl} <= st_q[MASK_LSB +: MASK_W];
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wp_d = wp_q;
    pc_d = pc_q;
    st_d = st_q;
    nWp_d = nWp_q;
    nPc_d = nPc_q;
    nSt_d = nSt_q;
    vec_d = vec_q;
    newMask_d = newMask_q;
    doStore_d = doStore_q;
    isIrq_d = isIrq_q;
    setMask_d = setMask_q;
    block_d = block_q;
    done_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (pcLoad) begin
          pc_d = pcWData;
        end else if (pcAdvance) begin
          pc_d = pc_q + PC_STEP;
        end
        if (stLoad) st_d = stWData;
        if (instrDone) block_d = 1'b0;
        if (swReq) begin
          cnt_d = 3'h0;
          isIrq_d = 1'b0;
          setMask_d = 1'b0;
          doStore_d = swKind != SW_RETURN;
          if (swKind == SW_RETURN) begin
            state_d = ST_RESTORE;
          end else begin
            state_d = ST_FETCH;
            vec_d = (swKind == SW_EXTOP) ? EXTOP_BASE + {8'h00, extOpNum, 2'b00} : swVector;
          end
        end else if (takeLoad || takeLvl) begin
          state_d = ST_FETCH;
          cnt_d = 3'h0;
          doStore_d = 1'b1;
          isIrq_d = 1'b1;
          setMask_d = 1'b1;
          vec_d = takeLoad ? LOAD_VEC : lvlVector(lvl);
          newMask_d = takeLoad ? LOAD_MASK : {1'b0, lvl} - 4'h1;
        end
      end
      ST_RSTHOLD: begin
        // Held here while the code stands; its minimum length is the source's duty
        if (kind != CK_RESET) begin
          state_d = ST_FETCH;
          cnt_d = 3'h0;
          vec_d = RESET_VEC;
          doStore_d = 1'b0;
          isIrq_d = 1'b0;
          setMask_d = 1'b0;
          st_d = STATUS_CLEAR;
        end
      end
      ST_FETCH: begin
        if (memAck) begin
          if (cnt_q[1]) begin
            nPc_d = putByte(nPc_q, cnt_q[0], memRData);
          end else begin
            nWp_d = putByte(nWp_q, cnt_q[0], memRData);
          end
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == VEC_LAST) begin
            cnt_d = 3'h0;
            if (doStore_q) begin
              state_d = ST_STORE;
            end else begin
              wp_d = nWp_d;
              pc_d = nPc_d;
              done_d = 1'b1;
              state_d = ST_RUN;
            end
          end
        end
      end
      ST_STORE: begin
        if (memAck) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == CTX_LAST) begin
            wp_d = nWp_q;
            pc_d = nPc_q;
            if (setMask_q) st_d[MASK_LSB +: MASK_W] = newMask_q;
            block_d = isIrq_q;
            done_d = 1'b1;
            state_d = ST_RUN;
          end
        end
      end
      ST_RESTORE: begin
        if (memAck) begin
          case (cnt_q[2:1])
            2'h0: nWp_d = putByte(nWp_q, cnt_q[0], memRData);
            2'h1: nPc_d = putByte(nPc_q, cnt_q[0], memRData);
            default: nSt_d = putByte(nSt_q, cnt_q[0], memRData);
          endcase
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == CTX_LAST) begin
            wp_d = nWp_d;
            pc_d = nPc_d;
            st_d = nSt_d;
            done_d = 1'b1;
            state_d = ST_RUN;
          end
        end
      end
      default: state_d = ST_RUN;
    endcase
    // Reset code aborts anything in flight and holds off all bus activity
    if (kind == CK_RESET) begin
      state_d = ST_RSTHOLD;
      cnt_d = 3'h0;
      block_d = 1'b0;
      done_d = 1'b0;
    end
    memReq_d = state_d == ST_FETCH || state_d == ST_STORE || state_d == ST_RESTORE;
    memWe_d = state_d == ST_STORE;
    memWData_d = 8'h00;
    case (state_d)
      ST_FETCH: memAddr_d = vec_d + {11'h000, cnt_d};
      ST_STORE: begin
        memAddr_d = nWp_d[13:0] + SAVE_OFFSET + {11'h000, cnt_d};
        memWData_d = ctxByte(cnt_d, wp_q, pc_q, st_q);
      end
      ST_RESTORE: memAddr_d = wp_q[13:0] + SAVE_OFFSET + {11'h000, cnt_d};
      default: memAddr_d = memAddr_q;
    endcase
    regAddr_d = wp_q[13:0] + {9'h000, regSel, 1'b0};
  end
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= ST_RUN;
      cnt_q <= 3'h0;
      wp_q <= 16'h0000;
      pc_q <= 16'h0000;
      st_q <= STATUS_CLEAR;
      nWp_q <= 16'h0000;
      nPc_q <= 16'h0000;
      nSt_q <= 16'h0000;
      vec_q <= RESET_VEC;
      newMask_q <= 4'h0;
      doStore_q <= 1'b0;
      isIrq_q <= 1'b0;
      setMask_q <= 1'b0;
      block_q <= 1'b0;
      done_q <= 1'b0;
      memReq_q <= 1'b0;
      memWe_q <= 1'b0;
      memAddr_q <= 14'h0000;
      memWData_q <= 8'h00;
      regAddr_q <= 14'h0000;
    end else if (clkEn) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wp_q <= wp_d;
      pc_q <= pc_d;
      st_q <= st_d;
      nWp_q <= nWp_d;
      nPc_q <= nPc_d;
      nSt_q <= nSt_d;
      vec_q <= vec_d;
      newMask_q <= newMask_d;
      doStore_q <= doStore_d;
      isIrq_q <= isIrq_d;
      setMask_q <= setMask_d;
      block_q <= block_d;
      done_q <= done_d;
      memReq_q <= memReq_d;
      memWe_q <= memWe_d;
      memAddr_q <= memAddr_d;
      memWData_q <= memWData_d;
      regAddr_q <= regAddr_d;
    end
  end
  assign memReq = memReq_q;
  assign memWe = memWe_q;
  assign memAddr = memAddr_q;
  assign memWData = memWData_q;
  assign workspacePtr = wp_q;
  assign programCounter = pc_q;
  assign statusWord = st_q;
  assign regAddr = regAddr_q;
  assign busy = state_q != ST_RUN;
  assign writeInhibit = state_q == ST_RSTHOLD;
  assign switchDone = done_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSync_q);
  sequence s_vec_start(logic [13:0] a);
    state_q == ST_FETCH && memReq && !memWe && memAddr == a;
  endsequence
  a_reset_hold: assert property (clkEn && kind == CK_RESET |=> state_q == ST_RSTHOLD && !memReq && !memWe)
    else $error("reset code did not hold off the bus");
  a_reset_vector: assert property (clkEn && state_q == ST_RSTHOLD && kind != CK_RESET
    |=> s_vec_start(RESET_VEC) and statusWord == STATUS_CLEAR)
    else $error("reset exit did not fetch from zero with cleared status");
  a_reset_pc_word: assert property (state_q == ST_FETCH && !doStore_q && vec_q == RESET_VEC && cnt_q == 3'h2
    |-> memAddr == 14'h0002)
    else $error("reset program counter not taken from second word");
  a_load_vector: assert property (clkEn && takeLoad && kind == CK_LOAD |=> s_vec_start(LOAD_VEC))
    else $error("load trap vector address wrong");
  a_level_vector: assert property (clkEn && takeLvl |=> s_vec_start({9'h000, $past(lvl), 2'b00}))
    else $error("level vector address wrong");
  a_extop_vector: assert property (clkEn && state_q == ST_RUN && swReq && swKind == SW_EXTOP && kind != CK_RESET
    |=> memAddr == EXTOP_BASE + {8'h00, $past(extOpNum), 2'b00})
    else $error("extended operation vector address wrong");
  a_even_word: assert property (state_q == ST_FETCH && memReq && cnt_q == 3'h0 |-> !memAddr[0])
    else $error("vector word fetch started on odd byte");
  a_save_slot: assert property (state_q == ST_STORE && cnt_q == 3'h0 |-> memWe && memAddr == nWp_q[13:0] + SAVE_OFFSET)
    else $error("old context not saved at register 13");
  a_store_follow: assert property (clkEn && state_q == ST_FETCH && memAck && cnt_q == VEC_LAST && doStore_q
    && kind != CK_RESET |=> state_q == ST_STORE && cnt_q == 3'h0 && memWe)
    else $error("vector fetch not followed by context store");
  a_mask_set: assert property (clkEn && state_q == ST_STORE && memAck && cnt_q == CTX_LAST && setMask_q
    && kind != CK_RESET |=> statusWord[MASK_LSB +: MASK_W] == $past(newMask_q) && block_q && switchDone)
    else $error("interrupt mask not lowered on entry");
  a_first_insn: assert property (clkEn && state_q == ST_RUN && block_q && !swReq && kind != CK_RESET
    |=> state_q == ST_RUN)
    else $error("interrupt taken before first service instruction ended");
  a_mask_reject: assert property (clkEn && atBoundary && kind == CK_LEVEL && {1'b0, lvl} > st_q[MASK_LSB +: MASK_W]
    |=> state_q == ST_RUN)
    else $error("masked level was accepted");
  a_pc_step: assert property (clkEn && state_q == ST_RUN && pcAdvance && !pcLoad && !swReq && kind != CK_RESET
    |=> programCounter == $past(programCounter) + PC_STEP)
    else $error("program counter did not advance by one word");
  a_reg_addr: assert property (clkEn |=> regAddr == $past(workspacePtr[13:0]) + {9'h000, $past(regSel), 1'b0})
    else $error("register address not workspace plus offset");
  a_return_pc: assert property (clkEn && state_q == ST_RESTORE && memAck && cnt_q == CTX_LAST && kind != CK_RESET
    |=> programCounter == $past(nPc_q) && workspacePtr == $past(nWp_q) && switchDone)
    else $error("return did not restore saved context");
endmodule

// ===== tb/ecs_mem_model.sv
`timescale 1ns/1ns
module ecs_mem_model (
  input wire logic ref_clk,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [13:0] memAddr,
  input wire logic [7:0] memWData,
  input wire logic slow,
  output logic memAck,
  output logic [7:0] memRData
);
  logic [7:0] mem [0:16383];
  logic [7:0] pat = 8'h5A;
  int rdCnt = 0;
  int wrCnt = 0;
  // Unacknowledged cycles show a moving pattern so stale data never passes
  assign memRData = memAck ? mem[memAddr] : pat;
  always @(posedge ref_clk) begin
    pat <= pat + 8'h01;
    memAck <= memReq && !(slow && memAck);
    if (memReq && memAck) begin
      if (memWe) begin
        mem[memAddr] <= memWData;
        wrCnt <= wrCnt + 1;
      end else begin
        rdCnt <= rdCnt + 1;
      end
    end
  end
endmodule

// ===== tb/ecs_top_tb.sv
`timescale 1ns/1ns
module ecs_top_tb import ecs_pkg::*;;
  logic ref_clk, rstn, instrDone, pcAdvance, pcLoad, stLoad, swReq, memAck, slow;
  logic [2:0] code;
  logic [15:0] pcWData, stWData;
  logic [1:0] swKind;
  logic [13:0] swVector;
  logic [3:0] extOpNum, regSel;
  logic [7:0] memRData, memWData;
  logic memReq, memWe, busy, writeInhibit, switchDone;
  logic [13:0] memAddr, regAddr;
  logic [15:0] workspacePtr, programCounter, statusWord;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;

  ecs_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .clkEn(1'b1), .interruptCodeLines(code),
    .instrDone(instrDone), .pcAdvance(pcAdvance), .pcLoad(pcLoad), .pcWData(pcWData),
    .stLoad(stLoad), .stWData(stWData), .swReq(swReq), .swKind(swKind), .swVector(swVector),
    .extOpNum(extOpNum), .regSel(regSel), .memAck(memAck), .memRData(memRData), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memWData(memWData), .workspacePtr(workspacePtr),
    .programCounter(programCounter), .statusWord(statusWord), .regAddr(regAddr), .busy(busy),
    .writeInhibit(writeInhibit), .switchDone(switchDone));
  ecs_mem_model u_mem (.ref_clk(ref_clk), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWData(memWData), .slow(slow), .memAck(memAck), .memRData(memRData));

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic setw(input logic [13:0] a, input logic [15:0] v);
    u_mem.mem[a] = v[15:8];
    u_mem.mem[a + 14'h0001] = v[7:0];
  endtask
  function automatic logic [15:0] getw(input logic [15:0] a);
    return {u_mem.mem[a[13:0]], u_mem.mem[a[13:0] + 14'h0001]};
  endfunction
  task automatic pulseDone();
    @(posedge ref_clk) instrDone <= 1'b1;
    @(posedge ref_clk) instrDone <= 1'b0;
  endtask
  // Code lines pass a two-flop synchroniser, so allow it to settle
  task automatic setCode(input logic [2:0] c);
    @(posedge ref_clk) code <= c;
    cyc(3);
  endtask
  task automatic loadSt(input logic [15:0] v);
    @(posedge ref_clk) begin
      stLoad <= 1'b1;
      stWData <= v;
    end
    @(posedge ref_clk) stLoad <= 1'b0;
  endtask
  task automatic swPulse(input logic [1:0] k);
    @(posedge ref_clk) begin
      swReq <= 1'b1;
      swKind <= k;
    end
    @(posedge ref_clk) swReq <= 1'b0;
  endtask
  task automatic waitDone();
    bit seen;
    seen = 0;
    for (int i = 0; i < 100 && !seen; i++) begin
      @(negedge ref_clk);
      if (switchDone === 1'b1) seen = 1;
    end
    chk("switchDone", 16'h0001, {15'h0000, seen});
  endtask
  task automatic chkCtx(input logic [15:0] w, input logic [15:0] p, input logic [15:0] s);
    chk("workspacePtr", w, workspacePtr);
    chk("programCounter", p, programCounter);
    chk("statusWord", s, statusWord);
  endtask
  // Old context sits in registers 13..15 of the new workspace
  task automatic chkSaved(input logic [15:0] w, input logic [15:0] ow, input logic [15:0] op,
      input logic [15:0] os);
    chk("saved wp", ow, getw(w + 16'h001A));
    chk("saved pc", op, getw(w + 16'h001C));
    chk("saved st", os, getw(w + 16'h001E));
  endtask

  task automatic resetTest();
    int r0;
    r0 = u_mem.rdCnt;
    @(negedge ref_clk);
    chk("writeInhibit", 16'h0001, {15'h0000, writeInhibit});
    chk("memReq", 16'h0000, {15'h0000, memReq});
    @(posedge ref_clk) code <= IC_NONE;
    waitDone();
    chkCtx(16'h0100, 16'h0200, 16'h0000);
    chk("fetches", 16'h0004, 16'(u_mem.rdCnt - r0));
    pulseDone();
    $display("test reset done");
  endtask
  task automatic pcTest();
    @(posedge ref_clk) pcAdvance <= 1'b1;
    @(posedge ref_clk) pcAdvance <= 1'b0;
    @(negedge ref_clk) chk("pc advance", 16'h0202, programCounter);
    @(posedge ref_clk) regSel <= 4'hF;
    cyc(2);
    @(negedge ref_clk) chk("regAddr", 16'h011E, {2'b00, regAddr});
    @(posedge ref_clk) begin
      pcLoad <= 1'b1;
      pcAdvance <= 1'b1;
      pcWData <= 16'h1234;
    end
    @(posedge ref_clk) begin
      pcLoad <= 1'b0;
      pcAdvance <= 1'b0;
    end
    @(negedge ref_clk) chk("pc load", 16'h1234, programCounter);
    $display("test pc done");
  endtask
  task automatic trapLevel(input logic [2:0] l);
    logic [15:0] ow, op, os, nw, np;
    int r0, w0;
    ow = workspacePtr;
    op = programCounter;
    os = {13'h0000, l};
    nw = {2'b00, l, 11'h000};
    np = {8'h0A, 5'h00, l};
    setw({9'h000, l, 2'b00}, nw);
    setw({9'h000, l, 2'b10}, np);
    loadSt(os);
    r0 = u_mem.rdCnt;
    w0 = u_mem.wrCnt;
    setCode(l + 3'h2);
    pulseDone();
    waitDone();
    chkCtx(nw, np, {13'h0000, l - 3'h1});
    chkSaved(nw, ow, op, os);
    chk("fetches", 16'h0004, 16'(u_mem.rdCnt - r0));
    chk("stores", 16'h0006, 16'(u_mem.wrCnt - w0));
  endtask
  task automatic levelTest();
    for (int l = 1; l <= 4; l++) begin
      trapLevel(3'(l));
      pulseDone();
      setCode(IC_NONE);
    end
    loadSt(16'h0001);
    setCode(3'h4);
    pulseDone();
    cyc(6);
    @(negedge ref_clk) chk("busy masked", 16'h0000, {15'h0000, busy});
    chk("wp masked", 16'h2000, workspacePtr);
    setCode(IC_NONE);
    $display("test levels done");
  endtask
  task automatic nestTest();
    logic [15:0] w3, p3;
    int r0;
    setw(14'h3FFC, 16'h3000);
    setw(14'h3FFE, 16'h0B00);
    trapLevel(3'h3);
    w3 = workspacePtr;
    p3 = programCounter;
    setCode(IC_LOAD);
    pulseDone();
    cyc(4);
    @(negedge ref_clk) chk("busy blocked", 16'h0000, {15'h0000, busy});
    pulseDone();
    waitDone();
    chkCtx(16'h3000, 16'h0B00, 16'h0000);
    chkSaved(16'h3000, w3, p3, 16'h0002);
    setCode(IC_NONE);
    pulseDone();
    r0 = u_mem.rdCnt;
    swPulse(SW_RETURN);
    waitDone();
    chkCtx(w3, p3, 16'h0002);
    chk("return fetches", 16'h0006, 16'(u_mem.rdCnt - r0));
    $display("test nest done");
  endtask
  task automatic swTest(input logic [1:0] k, input logic [13:0] va, input logic [15:0] nw,
      input logic [15:0] np);
    logic [15:0] ow, op, os;
    int w0;
    setw(va, nw);
    setw(va + 14'h0002, np);
    ow = workspacePtr;
    op = programCounter;
    os = statusWord;
    w0 = u_mem.wrCnt;
    swPulse(k);
    waitDone();
    chkCtx(nw, np, os);
    chkSaved(nw, ow, op, os);
    chk("stores", 16'h0006, 16'(u_mem.wrCnt - w0));
    $display("test switch kind %0d done", k);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      $display("Error timeout expected finish seen hang");
      summarize();
    end
  end
  initial begin
    {rstn, instrDone, pcAdvance, pcLoad, stLoad, swReq, slow} = '0;
    code = 3'h0;
    pcWData = 16'h0000;
    stWData = 16'h0000;
    swKind = SW_CALL;
    swVector = 14'h0030;
    extOpNum = 4'h3;
    regSel = 4'h0;
    setw(14'h0000, 16'h0100);
    setw(14'h0002, 16'h0200);
    cyc(4);
    @(posedge ref_clk) rstn <= 1'b1;
    // Two reset flops and two code flops pass before the hold state is entered
    cyc(5);
    resetTest();
    pcTest();
    levelTest();
    nestTest();
    @(posedge ref_clk) slow <= 1'b1;
    swTest(SW_CALL, 14'h0030, 16'h3400, 16'h0C00);
    swTest(SW_EXTOP, 14'h004C, 16'h3800, 16'h0C40);
    summarize();
  end
endmodule
